// *** cc_timer_pkg.sv ***
// constants for the two channel capture/compare timer
// assumes byte-wide register port and a single bus clock
package cc_timer_pkg;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam int ADDR_W = 5;
  localparam logic [4:0] A_TIMER_STATUS_CONTROL = 5'h00;
  localparam logic [4:0] A_COUNTER_HIGH_BYTE = 5'h01;
  localparam logic [4:0] A_COUNTER_LOW_BYTE = 5'h02;
  localparam logic [4:0] A_WRAP_VALUE_HIGH_BYTE = 5'h03;
  localparam logic [4:0] A_WRAP_VALUE_LOW_BYTE = 5'h04;
  // channel i: status at base + 3*i, value high at +1, value low at +2
  localparam logic [4:0] A_CHANNEL_BASE = 5'h05;
  localparam logic [4:0] A_CHANNEL_STRIDE = 5'h03;

  // ****************************************************************
  // timer_status_control fields
  // ****************************************************************
  localparam int B_OVERFLOW_FLAG = 7;
  localparam int B_OVERFLOW_IRQ_ENABLE = 6;
  localparam int B_COUNTER_HALT = 5;
  localparam int B_COUNTER_CLEAR = 4;
  localparam int B_PRESCALE_HI = 2;

  // ****************************************************************
  // channel status/control fields
  // ****************************************************************
  localparam int B_CHANNEL_EVENT_FLAG = 7;
  localparam int B_CHANNEL_IRQ_ENABLE = 6;
  localparam int B_BUFFERED_MODE_SELECT = 5;
  localparam int B_MODE_SELECT_A = 4;
  localparam int B_EDGE_LEVEL_B = 3;
  localparam int B_EDGE_LEVEL_A = 2;
  localparam int B_TOGGLE_AT_WRAP = 1;
  localparam int B_DUTY_MAX = 0;

  // ****************************************************************
  // reset values and codes
  // ****************************************************************
  localparam logic [15:0] WRAP_RESET = 16'hFFFF;
  localparam logic [2:0] PRESCALE_NONE = 3'h7;
  localparam logic [1:0] EL_PORT = 2'h0;
  localparam logic [1:0] EL_TOGGLE_RISE = 2'h1;
  localparam logic [1:0] EL_CLEAR_FALL = 2'h2;
  localparam logic [1:0] EL_SET_BOTH = 2'h3;

endpackage : cc_timer_pkg

// *** cc_timer.sv ***
// two channel 16-bit capture/compare timer with prescaler and wrap value
// assumes wait/stop levels and register strobes come from ref_clk logic
`timescale 1ns/100ps
module cc_timer (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [cc_timer_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic channel0_pin_in,
  output logic channel0_pin_out,
  output logic channel0_pin_oe,
  input wire logic channel1_pin_in,
  output logic channel1_pin_out,
  output logic channel1_pin_oe,
  output logic overflow_irq,
  output logic [1:0] channel_irq,
  output logic wake_request
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] rdata;
    logic overflow_flag;
    logic ovf_armed;
    logic overflow_irq_enable;
    logic counter_halt;
    logic [2:0] prescale_select;
    logic [6:0] presc;
    logic [15:0] cnt;
    logic [7:0] low_buf;
    logic low_latched;
    logic [15:0] wrap;
    logic wrap_hold;
    logic [1:0] channel_event_flag;
    logic [1:0] ch_armed;
    logic [1:0] channel_irq_enable;
    logic [1:0] mode_select_a;
    logic [1:0] edge_level_b;
    logic [1:0] edge_level_a;
    logic [1:0] toggle_at_wrap;
    logic [1:0] duty_max;
    logic [1:0][15:0] chv;
    logic [1:0] cmp_hold;
    logic [1:0] cap_hold;
    logic [1:0] level;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] sync3;
    logic [1:0] pin_level;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic buffered_mode_select;
    logic use_ch1;
    logic ch1_last;
    logic ovf_irq;
    logic [1:0] ch_irq;
    logic wake;
  } state_s;

  state_s s;
  state_s next_s;
  logic tick;
  logic wrap_hit;
  logic ovf;
  logic [1:0] cap;
  logic [1:0] cmp;
  logic [1:0] ch_en;
  logic [1:0] cap_mode;
  logic [1:0] cmp_mode;
  logic acc_rd;
  logic acc_wr;
  logic [15:0] cnt_next;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // prescaler tap: code n ticks every 2^n bus clocks, code 7 never ticks
  function automatic logic presc_tick(input logic [6:0] p, input logic [2:0] sel);
    logic [6:0] mask;
    mask = 7'(({7'h00, 1'b1} << sel) - 8'h01);
    presc_tick = (sel != cc_timer_pkg::PRESCALE_NONE) && ((p & mask) == mask);
  endfunction : presc_tick

  function automatic logic [4:0] ch_addr(input int i, input logic [4:0] off);
    ch_addr = 5'(cc_timer_pkg::A_CHANNEL_BASE + 5'(i) * cc_timer_pkg::A_CHANNEL_STRIDE + off);
  endfunction : ch_addr

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.rdata = 8'h00;
    // no register access while the core sleeps in wait mode
    acc_rd = rd && !wait_mode;
    acc_wr = wr && !wait_mode;
    // pin sync; a change counts once stages two and three agree
    next_s.sync1 = {channel1_pin_in, channel0_pin_in};
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    for (int i = 0; i < 2; i++) begin
      if (s.sync2[i] == s.sync3[i]) begin
        next_s.pin_level[i] = s.sync2[i];
      end
    end
    // prescaler and counter, frozen in stop mode
    tick = !stop_mode && !s.counter_halt && presc_tick(s.presc, s.prescale_select);
    if (!stop_mode && !s.counter_halt) begin
      next_s.presc = 7'(s.presc + 7'h01);
    end
    cnt_next = (s.cnt == s.wrap) ? 16'h0000 : 16'(s.cnt + 16'h0001);
    if (tick) begin
      next_s.cnt = cnt_next;
    end
    wrap_hit = tick && (cnt_next == s.wrap);
    ovf = wrap_hit && !s.wrap_hold;
    // buffered pair swaps to the last written value at each wrap
    if (wrap_hit && s.buffered_mode_select) begin
      next_s.use_ch1 = s.ch1_last;
    end
    // channel modes and events
    for (int i = 0; i < 2; i++) begin
      logic buf0;
      logic [1:0] els;
      logic [15:0] cv;
      buf0 = (i == 0) && s.buffered_mode_select;
      els = {s.edge_level_b[i], s.edge_level_a[i]};
      ch_en[i] = !((i == 1) && s.buffered_mode_select);
      cap_mode[i] = ch_en[i] && (els != cc_timer_pkg::EL_PORT) && !s.mode_select_a[i] && !buf0;
      cmp_mode[i] = ch_en[i] && (s.mode_select_a[i] || buf0);
      cv = (buf0 && s.use_ch1) ? s.chv[1] : s.chv[i];
      cmp[i] = tick && cmp_mode[i] && !s.cmp_hold[i] && (cnt_next == cv);
      cap[i] = !stop_mode && cap_mode[i] && !s.cap_hold[i] && (s.sync2[i] == s.sync3[i]) &&
        ((els[0] && s.sync2[i] && !s.pin_level[i]) || (els[1] && !s.sync2[i] && s.pin_level[i]));
      // pin level: preset, then wrap toggle wins over compare action
      if (els == cc_timer_pkg::EL_PORT) begin
        next_s.level[i] = !s.mode_select_a[i];
      end else if (cmp_mode[i]) begin
        if (wrap_hit && s.toggle_at_wrap[i]) begin
          next_s.level[i] = !s.level[i];
        end else if (cmp[i]) begin
          case (els)
            cc_timer_pkg::EL_TOGGLE_RISE: next_s.level[i] = !s.level[i];
            cc_timer_pkg::EL_CLEAR_FALL: next_s.level[i] = 1'b0;
            cc_timer_pkg::EL_SET_BOTH: next_s.level[i] = 1'b1;
            default: next_s.level[i] = s.level[i];
          endcase
        end
      end
      next_s.pin_oe[i] = cmp_mode[i] && (els != cc_timer_pkg::EL_PORT);
      next_s.pin_out[i] = (s.toggle_at_wrap[i] && s.duty_max[i] &&
        (els == cc_timer_pkg::EL_CLEAR_FALL)) ? 1'b1 : next_s.level[i];
    end
    // ****************************************************************
    // register reads
    // ****************************************************************
    if (acc_rd) begin
      case (addr)
        cc_timer_pkg::A_TIMER_STATUS_CONTROL: begin
          next_s.rdata = {s.overflow_flag, s.overflow_irq_enable, s.counter_halt, 1'b0, 1'b0,
            s.prescale_select};
          if (s.overflow_flag) begin
            next_s.ovf_armed = 1'b1;
          end
        end
        cc_timer_pkg::A_COUNTER_HIGH_BYTE: begin
          next_s.rdata = s.cnt[15:8];
          if (!s.low_latched) begin
            next_s.low_buf = s.cnt[7:0];
            next_s.low_latched = 1'b1;
          end
        end
        cc_timer_pkg::A_COUNTER_LOW_BYTE: begin
          next_s.rdata = s.low_latched ? s.low_buf : s.cnt[7:0];
          next_s.low_latched = 1'b0;
        end
        cc_timer_pkg::A_WRAP_VALUE_HIGH_BYTE: next_s.rdata = s.wrap[15:8];
        cc_timer_pkg::A_WRAP_VALUE_LOW_BYTE: next_s.rdata = s.wrap[7:0];
        default: next_s.rdata = 8'h00;
      endcase
      for (int i = 0; i < 2; i++) begin
        if (addr == ch_addr(i, 5'h00) && ch_en[i]) begin
          next_s.rdata = {s.channel_event_flag[i], s.channel_irq_enable[i],
            (i == 0) ? s.buffered_mode_select : 1'b0, s.mode_select_a[i], s.edge_level_b[i],
            s.edge_level_a[i], s.toggle_at_wrap[i], s.duty_max[i]};
          if (s.channel_event_flag[i]) begin
            next_s.ch_armed[i] = 1'b1;
          end
        end
        if (addr == ch_addr(i, 5'h01)) begin
          next_s.rdata = s.chv[i][15:8];
          if (!s.mode_select_a[i] && !((i == 0) && s.buffered_mode_select)) begin
            next_s.cap_hold[i] = 1'b1;
          end
        end
        if (addr == ch_addr(i, 5'h02)) begin
          next_s.rdata = s.chv[i][7:0];
          next_s.cap_hold[i] = 1'b0;
        end
      end
    end
    // ****************************************************************
    // register writes
    // ****************************************************************
    if (acc_wr) begin
      case (addr)
        cc_timer_pkg::A_TIMER_STATUS_CONTROL: begin
          next_s.overflow_irq_enable = wdata[cc_timer_pkg::B_OVERFLOW_IRQ_ENABLE];
          next_s.counter_halt = wdata[cc_timer_pkg::B_COUNTER_HALT];
          next_s.prescale_select = wdata[cc_timer_pkg::B_PRESCALE_HI:0];
          // writing 1 to the flag does nothing
          if (!wdata[cc_timer_pkg::B_OVERFLOW_FLAG] && s.ovf_armed) begin
            next_s.overflow_flag = 1'b0;
          end
          next_s.ovf_armed = 1'b0;
          if (wdata[cc_timer_pkg::B_COUNTER_CLEAR]) begin
            next_s.cnt = 16'h0000;
            next_s.presc = 7'h00;
          end
        end
        cc_timer_pkg::A_WRAP_VALUE_HIGH_BYTE: begin
          next_s.wrap[15:8] = wdata;
          next_s.wrap_hold = 1'b1;
        end
        cc_timer_pkg::A_WRAP_VALUE_LOW_BYTE: begin
          next_s.wrap[7:0] = wdata;
          next_s.wrap_hold = 1'b0;
        end
        default: next_s.wrap_hold = s.wrap_hold;
      endcase
      for (int i = 0; i < 2; i++) begin
        if (addr == ch_addr(i, 5'h00) && ch_en[i]) begin
          next_s.channel_irq_enable[i] = wdata[cc_timer_pkg::B_CHANNEL_IRQ_ENABLE];
          next_s.mode_select_a[i] = wdata[cc_timer_pkg::B_MODE_SELECT_A];
          next_s.edge_level_b[i] = wdata[cc_timer_pkg::B_EDGE_LEVEL_B];
          next_s.edge_level_a[i] = wdata[cc_timer_pkg::B_EDGE_LEVEL_A];
          next_s.toggle_at_wrap[i] = wdata[cc_timer_pkg::B_TOGGLE_AT_WRAP];
          next_s.duty_max[i] = wdata[cc_timer_pkg::B_DUTY_MAX];
          if (i == 0) begin
            next_s.buffered_mode_select = wdata[cc_timer_pkg::B_BUFFERED_MODE_SELECT];
          end
          if (!wdata[cc_timer_pkg::B_CHANNEL_EVENT_FLAG] && s.ch_armed[i]) begin
            next_s.channel_event_flag[i] = 1'b0;
          end
          next_s.ch_armed[i] = 1'b0;
        end
        if (addr == ch_addr(i, 5'h01)) begin
          next_s.chv[i][15:8] = wdata;
          if (cmp_mode[i] || ((i == 1) && s.buffered_mode_select)) begin
            next_s.cmp_hold[i] = 1'b1;
          end
        end
        if (addr == ch_addr(i, 5'h02)) begin
          next_s.chv[i][7:0] = wdata;
          next_s.cmp_hold[i] = 1'b0;
          next_s.ch1_last = (i == 1);
        end
      end
    end
    // ****************************************************************
    // events last: a set wins over a same-cycle clear
    // ****************************************************************
    if (ovf) begin
      next_s.overflow_flag = 1'b1;
      next_s.ovf_armed = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (cap[i]) begin
        next_s.chv[i] = s.cnt;
      end
      if (cap[i] || cmp[i]) begin
        next_s.channel_event_flag[i] = 1'b1;
        next_s.ch_armed[i] = 1'b0;
      end
      next_s.ch_irq[i] = next_s.channel_event_flag[i] && next_s.channel_irq_enable[i] &&
        !((i == 1) && next_s.buffered_mode_select);
    end
    next_s.ovf_irq = next_s.overflow_flag && next_s.overflow_irq_enable;
    next_s.wake = next_s.ovf_irq || (|next_s.ch_irq);
  end
  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.counter_halt <= 1'b1;
      s.wrap <= cc_timer_pkg::WRAP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign channel0_pin_out = s.pin_out[0];
  assign channel0_pin_oe = s.pin_oe[0];
  assign channel1_pin_out = s.pin_out[1];
  assign channel1_pin_oe = s.pin_oe[1];
  assign overflow_irq = s.ovf_irq;
  assign channel_irq = s.ch_irq;
  assign wake_request = s.wake;
  // ****************************************************************
  // checks
  // ****************************************************************
  property p_wrap_restart;
    @(posedge ref_clk) disable iff (!rst_b)
      tick && (s.cnt == s.wrap) && !acc_wr |=> s.cnt == 16'h0000;
  endproperty
  a_wrap_restart: assert property (p_wrap_restart) else $error("no restart at wrap");
  property p_overflow_sets;
    @(posedge ref_clk) disable iff (!rst_b)
      ovf |=> s.overflow_flag ##1 s.ovf_irq == s.overflow_irq_enable;
  endproperty
  a_overflow_sets: assert property (p_overflow_sets) else $error("overflow lost");
  property p_irq_gate;
    @(posedge ref_clk) disable iff (!rst_b)
      s.ovf_irq |-> s.overflow_flag && s.overflow_irq_enable;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("overflow request ungated");
  property p_write_one_keeps;
    @(posedge ref_clk) disable iff (!rst_b)
      acc_wr && addr == cc_timer_pkg::A_TIMER_STATUS_CONTROL && wdata[7] && s.overflow_flag
      |=> s.overflow_flag;
  endproperty
  a_write_one_keeps: assert property (p_write_one_keeps) else $error("flag cleared by 1");
  property p_halt_holds;
    @(posedge ref_clk) disable iff (!rst_b)
      s.counter_halt && !acc_wr |=> $stable(s.cnt) && $stable(s.presc);
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("counter moved while halted");
  property p_clear_zero;
    @(posedge ref_clk) disable iff (!rst_b)
      acc_wr && addr == cc_timer_pkg::A_TIMER_STATUS_CONTROL && wdata[4] && wdata[5]
      |=> s.cnt == 16'h0000 ##1 s.cnt == 16'h0000;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("halt with clear not at zero");
  property p_latch_low;
    @(posedge ref_clk) disable iff (!rst_b)
      acc_rd && addr == cc_timer_pkg::A_COUNTER_HIGH_BYTE && !s.low_latched
      |=> s.low_latched && s.low_buf == $past(s.cnt[7:0]);
  endproperty
  a_latch_low: assert property (p_latch_low) else $error("low byte not latched");
  property p_wrap_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      s.wrap_hold && !s.overflow_flag |=> !s.overflow_flag;
  endproperty
  a_wrap_hold: assert property (p_wrap_hold) else $error("overflow during wrap write");
  property p_capture_flag;
    @(posedge ref_clk) disable iff (!rst_b)
      cap[1] |=> s.channel_event_flag[1] && s.chv[1] == $past(s.cnt);
  endproperty
  a_capture_flag: assert property (p_capture_flag) else $error("capture not recorded");
  property p_stop_freeze;
    @(posedge ref_clk) disable iff (!rst_b)
      stop_mode && !acc_wr |=> $stable(s.cnt);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("counter ran in stop");

endmodule : cc_timer

// *** pin_far_end.sv ***
// far end of one timer channel pin: port logic plus outside driver
// assumes no pull resistor on the pin, so a floating pin wanders
`timescale 1ns/100ps
module pin_far_end (
  input wire logic ref_clk,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic drv_en,
  input wire logic drv_lvl,
  output logic pin_in
);
  // undriven pin must not look like a stable level
  logic wander = 1'b0;
  always @(posedge ref_clk) begin
    wander <= ~wander;
  end
  // timer output wins over the outside driver
  always_comb begin
    if (pin_oe) begin
      pin_in = pin_out;
    end else if (drv_en) begin
      pin_in = drv_lvl;
    end else begin
      pin_in = wander;
    end
  end
endmodule : pin_far_end

// *** tb_top.sv ***
// self-checking bench for cc_timer over its byte register port
// assumes pin_far_end sits on both channel pins
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s expected %0h seen %0h", n, e, g); end end
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic [1:0] drv_en = 2'h0;
  logic [1:0] drv_lvl = 2'h0;
  logic [7:0] rdata, d;
  logic [1:0] pin_in, pin_out, pin_oe, channel_irq;
  logic overflow_irq, wake_request, p;
  logic [15:0] c0, c1;
  int num_errors = 0;
  int check_count = 0;
  int e;
  cc_timer dut (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .channel0_pin_in(pin_in[0]), .channel0_pin_out(pin_out[0]), .channel0_pin_oe(pin_oe[0]),
    .channel1_pin_in(pin_in[1]), .channel1_pin_out(pin_out[1]), .channel1_pin_oe(pin_oe[1]),
    .overflow_irq(overflow_irq), .channel_irq(channel_irq), .wake_request(wake_request));
  for (genvar i = 0; i < 2; i++) begin : g_pin
    pin_far_end far (.ref_clk(ref_clk), .pin_out(pin_out[i]), .pin_oe(pin_oe[i]),
      .drv_en(drv_en[i]), .drv_lvl(drv_lvl[i]), .pin_in(pin_in[i]));
  end
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg
  // high first: it latches the low byte
  task automatic rd_cnt(output logic [15:0] v);
    rd_reg(5'h01, v[15:8]);
    rd_reg(5'h02, v[7:0]);
  endtask : rd_cnt
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_n
  task automatic test_done();
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  // ****************************************************************
  // clock, watchdog, tests
  // ****************************************************************
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    #(40 * 20000);
    num_errors++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_reg(5'h00, d); `CHK("status", 8'h20, d)
    rd_reg(5'h03, d); `CHK("wrap hi", 8'hFF, d)
    rd_reg(5'h04, d); `CHK("wrap lo", 8'hFF, d)
    rd_cnt(c0); `CHK("count", 16'h0000, c0)
    for (int k = 0; k < 8; k++) begin
      wr_reg(5'h00, 8'h30);
      wr_reg(5'h00, {5'h00, k[2:0]});
      wait_n(256);
      wr_reg(5'h00, {5'h04, k[2:0]});
      rd_cnt(c0);
      e = (k == 7) ? 0 : (258 >> k);
      `CHK("prescale", 1'b1, (int'(c0) >= e - 2) && (int'(c0) <= e + 2))
    end
    // second high read 17 cycles later must not relatch
    wr_reg(5'h00, 8'h30);
    wr_reg(5'h00, 8'h00);
    wait_n(10);
    rd_reg(5'h01, d);
    wait_n(15);
    rd_reg(5'h01, d);
    wait_n(15);
    rd_reg(5'h02, c0[7:0]);
    wr_reg(5'h00, 8'h20);
    rd_cnt(c1);
    `CHK("latch", 1'b1, (c1[7:0] - c0[7:0] >= 8'h21) && (c1[7:0] - c0[7:0] <= 8'h27))
    wr_reg(5'h00, 8'h00);
    wait_n(5);
    wr_reg(5'h00, 8'h30);
    wait_n(5);
    rd_reg(5'h00, d); `CHK("status", 8'h20, d)
    rd_cnt(c0); `CHK("halt clear", 16'h0000, c0)
    wr_reg(5'h03, 8'h00);
    wr_reg(5'h00, 8'h40);
    wait_n(300);
    rd_reg(5'h00, d); `CHK("no ovf", 8'h40, d)
    wr_reg(5'h00, 8'h50);
    wr_reg(5'h04, 8'h03);
    wait_n(10);
    rd_reg(5'h00, d); `CHK("ovf", 8'hC0, d)
    `CHK("ovf irq", 1'b1, overflow_irq)
    wr_reg(5'h00, 8'h60);
    rd_cnt(c0); `CHK("wrap", 1'b1, c0 <= 16'h0003)
    rd_reg(5'h00, d); `CHK("armed", 8'hE0, d)
    wr_reg(5'h00, 8'hE0);
    rd_reg(5'h00, d); `CHK("write one", 8'hE0, d)
    wr_reg(5'h00, 8'h60);
    rd_reg(5'h00, d); `CHK("cleared", 8'h60, d)
    `CHK("ovf irq", 1'b0, overflow_irq)
    wr_reg(5'h00, 8'h40);
    wait_n(10);
    @(posedge ref_clk);
    wait_mode <= 1'b1;
    rd_reg(5'h00, d); `CHK("wait rd", 8'h00, d)
    `CHK("wake", 1'b1, wake_request)
    wr_reg(5'h00, 8'h30);
    @(posedge ref_clk);
    wait_mode <= 1'b0;
    rd_reg(5'h00, d); `CHK("after wait", 8'hC0, d)
    wr_reg(5'h00, 8'h30);
    wr_reg(5'h03, 8'hFF);
    wr_reg(5'h04, 8'hFF);
    wr_reg(5'h00, 8'h00);
    wait_n(5);
    @(posedge ref_clk);
    stop_mode <= 1'b1;
    wait_n(2);
    rd_cnt(c0);
    wait_n(20);
    rd_cnt(c1); `CHK("stop", c0, c1)
    @(posedge ref_clk);
    stop_mode <= 1'b0;
    wait_n(20);
    rd_cnt(c1);
    `CHK("resume", 1'b1, (c1 - c0 >= 16'h0014) && (c1 - c0 <= 16'h0020))
    // compare on channel 0 at count 0010, each output action
    wr_reg(5'h06, 8'h00);
    wr_reg(5'h07, 8'h10);
    for (int el = 1; el < 4; el++) begin
      wr_reg(5'h00, 8'h30);
      rd_reg(5'h05, d);
      wr_reg(5'h05, {4'h5, el[1:0], 2'h0});
      rd_reg(5'h05, d); `CHK("ch0 clr", {4'h5, el[1:0], 2'h0}, d)
      p = pin_out[0];
      wr_reg(5'h00, 8'h00);
      wait_n(40);
      rd_reg(5'h05, d); `CHK("ch0 flag", {4'hD, el[1:0], 2'h0}, d)
      `CHK("irq0", 1'b1, channel_irq[0])
      `CHK("oe0", 1'b1, pin_oe[0])
      `CHK("pin0", (el == 1) ? ~p : el[0], pin_out[0])
    end
    wr_reg(5'h00, 8'h30);
    wr_reg(5'h05, 8'h10);
    wait_n(2);
    `CHK("preset lo", 1'b0, pin_out[0])
    wr_reg(5'h05, 8'h00);
    wait_n(2);
    `CHK("preset hi", 1'b1, pin_out[0])
    // capture on channel 1, each edge code against both edges
    drv_en[1] <= 1'b1;
    for (int el = 1; el < 4; el++) begin
      drv_lvl[1] <= 1'b0;
      wait_n(5);
      rd_reg(5'h08, d);
      wr_reg(5'h08, {4'h4, el[1:0], 2'h0});
      drv_lvl[1] <= 1'b1;
      wait_n(8);
      rd_reg(5'h08, d); `CHK("rise", {el[0], 3'h4, el[1:0], 2'h0}, d)
      `CHK("irq1", el[0], channel_irq[1])
      wr_reg(5'h08, {4'h4, el[1:0], 2'h0});
      drv_lvl[1] <= 1'b0;
      wait_n(8);
      rd_reg(5'h08, d); `CHK("fall", {el[1], 3'h4, el[1:0], 2'h0}, d)
    end
    drv_en[1] <= 1'b0;
    wr_reg(5'h08, 8'h10);
    wr_reg(5'h08, 8'h14);
    wait_n(2);
    `CHK("oe1", 1'b1, pin_oe[1])
    `CHK("pin1", 1'b0, pin_out[1])
    wr_reg(5'h05, 8'h28);
    wait_n(1);
    rd_reg(5'h08, d); `CHK("ch1 off", 8'h00, d)
    `CHK("oe1 off", 1'b0, pin_oe[1])
    `CHK("oe0 buf", 1'b1, pin_oe[0])
    test_done();
  end
endmodule : tb_top
